// ==== logic/sar_adc_scan_control.sv ====
// Scan control of an eight-channel successive approximation converter.
// Assumes comparator and sample switch on the analog side, same clock
// timer tick, and an external trigger pin from outside the clock domain.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "adc_scan_consts.svh"
//
// Contract
// - Result resolution selectable, eight or ten bits
// - Any of eight channels converted
// - Stored result raises interrupt when enabled
// - Start by software, timer, or pin fall
// - Single mode stops after end channel
// - Continuous mode wraps to start channel
// - Pause mode halts after each channel
// - Conversion takes at least minimum time
// - Sampling lasts at least minimum period
// - Request auto transfer; hold results, no loss
module sar_adc_scan_control
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // Trigger sources
   input  wire logic        timer_tick,
   input  wire logic        ext_trig_pin,
   // Analog side
   input  wire logic        comp_in,
   output logic             sample_en,
   output logic      [9:0]  dac_code,
   output logic      [2:0]  chan_sel,
   // Events
   output logic             auto_transfer_req,
   output logic             irq
);
   import adc_scan_pkg::*;

   scan_state_t st_reg, st_next;
   logic [15:0] ctrl_reg, ctrl_next;
   logic [2:0]  mask_reg, mask_next;
   logic [2:0]  stat_reg, stat_next;
   logic [2:0]  ch_reg, ch_next;
   logic [12:0] data_reg, data_next;
   logic        pend_reg, pend_next;
   logic        tick_reg;
   logic [15:0] rdata_reg, rdata_next;

   logic       eng_start, eng_busy, eng_done;
   logic [9:0] eng_result;
   logic       ext_fall, timer_rise, soft_start, trigger, stop;
   logic       store, last, rd_data, rd_stat;
   scan_mode_t mode;
   trig_src_t  trig;
   logic [2:0] sch, ech;
   logic       res10, xfer_en;

   pin_fall_detect u_fall
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin      (ext_trig_pin),
      .fall     (ext_fall)
   );

   sar_engine u_eng
   (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .start     (eng_start),
      .abort     (stop),
      .res10     (res10),
      .comp_in   (comp_in),
      .sample_en (sample_en),
      .dac_code  (dac_code),
      .busy      (eng_busy),
      .done      (eng_done),
      .result    (eng_result)
   );

   // Decoded configuration
   always_comb
   begin
      mode    = scan_mode_t'(ctrl_reg[`CTRL_MODE_LSB +: 2]);
      trig    = trig_src_t'(ctrl_reg[`CTRL_TRIG_LSB +: 2]);
      res10   = ctrl_reg[`CTRL_RES10_BIT];
      xfer_en = ctrl_reg[`CTRL_XFER_BIT];
      sch     = ctrl_reg[`CTRL_SCH_LSB +: 3];
      ech     = ctrl_reg[`CTRL_ECH_LSB +: 3];
   end

   // Trigger selection
   always_comb
   begin
      timer_rise = timer_tick & ~tick_reg;
      soft_start = reg_wr && reg_addr == `ADC_OFF_CTRL && reg_wdata[`CTRL_START_BIT];
      stop       = reg_wr && reg_addr == `ADC_OFF_CTRL && reg_wdata[`CTRL_STOP_BIT];
      case (trig)
         TRIG_SOFT:  trigger = soft_start;
         TRIG_TIMER: trigger = timer_rise;
         TRIG_EXT:   trigger = ext_fall;
         default:    trigger = 1'b0;
      endcase
   end

   // Scan sequencing
   always_comb
   begin
      st_next   = st_reg;
      ch_next   = ch_reg;
      data_next = data_reg;
      eng_start = 1'b0;
      rd_data   = reg_rd && reg_addr == `ADC_OFF_DATA;
      store     = (st_reg == S_CONV && eng_done && !(pend_reg && xfer_en)) ||
                  (st_reg == S_HOLD && !pend_reg);
      last      = (ch_reg == ech);
      stat_next = stat_reg;
      if (reg_rd && reg_addr == `ADC_OFF_IRQ_STAT)
         stat_next = 3'h0;
      case (st_reg)
         S_IDLE:
         begin
            if (trigger)
            begin
               ch_next   = sch;
               eng_start = 1'b1;
               st_next   = S_CONV;
            end
         end
         S_CONV:
         begin
            if (eng_done && pend_reg && xfer_en)
               st_next = S_HOLD;
         end
         S_HOLD:
         begin
         end
         S_PAUSE:
         begin
            if (trigger)
            begin
               eng_start = 1'b1;
               st_next   = S_CONV;
            end
         end
         default: st_next = S_IDLE;
      endcase
      if (store)
      begin
         data_next = {ch_reg, eng_result};
         stat_next[`IRQ_DONE_BIT] = 1'b1;
         if (pend_reg && !rd_data)
            stat_next[`IRQ_OVR_BIT] = 1'b1;
         if (last)
         begin
            stat_next[`IRQ_END_BIT] = 1'b1;
            case (mode)
               MODE_CONT:
               begin
                  ch_next   = sch;
                  eng_start = 1'b1;
                  st_next   = S_CONV;
               end
               MODE_PAUSE:
               begin
                  ch_next = sch;
                  st_next = S_PAUSE;
               end
               default: st_next = S_IDLE;
            endcase
         end
         else
         begin
            ch_next = ch_reg + 3'h1;
            if (mode == MODE_PAUSE)
               st_next = S_PAUSE;
            else
            begin
               eng_start = 1'b1;
               st_next   = S_CONV;
            end
         end
      end
      pend_next = store ? 1'b1 : (rd_data ? 1'b0 : pend_reg);
      if (stop)
      begin
         st_next   = S_IDLE;
         eng_start = 1'b0;
      end
   end

   // Register port
   always_comb
   begin
      ctrl_next  = ctrl_reg;
      mask_next  = mask_reg;
      rdata_next = 16'h0000;
      if (reg_wr && reg_addr == `ADC_OFF_CTRL)
         ctrl_next = reg_wdata & `CTRL_WR_MASK;
      if (reg_wr && reg_addr == `ADC_OFF_IRQ_MASK)
         mask_next = reg_wdata[2:0];
      if (reg_rd)
      begin
         case (reg_addr)
            `ADC_OFF_CTRL:     rdata_next = ctrl_reg;
            `ADC_OFF_STATUS:   rdata_next = {10'h000, pend_reg, ch_reg, st_reg == S_PAUSE, st_reg != S_IDLE};
            `ADC_OFF_DATA:     rdata_next = {3'h0, data_reg};
            `ADC_OFF_IRQ_STAT: rdata_next = {13'h0000, stat_reg};
            `ADC_OFF_IRQ_MASK: rdata_next = {13'h0000, mask_reg};
            default:           rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg    <= S_IDLE;
         ctrl_reg  <= `CTRL_RST;
         mask_reg  <= `IRQ_MASK_RST;
         stat_reg  <= 3'h0;
         ch_reg    <= 3'h0;
         data_reg  <= 13'h0000;
         pend_reg  <= 1'b0;
         tick_reg  <= 1'b0;
         rdata_reg <= 16'h0000;
      end
      else
      begin
         st_reg    <= st_next;
         ctrl_reg  <= ctrl_next;
         mask_reg  <= mask_next;
         stat_reg  <= stat_next;
         ch_reg    <= ch_next;
         data_reg  <= data_next;
         pend_reg  <= pend_next;
         tick_reg  <= timer_tick;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata         = rdata_reg;
   assign chan_sel          = ch_reg;
   assign irq               = |(stat_reg & mask_reg);
   assign auto_transfer_req = pend_reg & xfer_en;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   AST_RES8: assert property (store && !res10 |=> data_reg[9:8] == 2'b00)
      else $error("eight-bit result has upper bits set");
   AST_CHAN: assert property (store |=> data_reg[12:10] == $past(ch_reg))
      else $error("stored channel mismatch");
   AST_IRQ: assert property (store && mask_reg[`IRQ_DONE_BIT] |=> irq)
      else $error("no interrupt after store");
   AST_TRIG: assert property (st_reg == S_IDLE && !trigger |=> st_reg == S_IDLE)
      else $error("scan started without trigger");
   AST_START: assert property (st_reg == S_IDLE && trigger && !stop |=> st_reg == S_CONV && ch_reg == $past(sch))
      else $error("trigger did not start at start channel");
   AST_SINGLE: assert property (store && last && mode == MODE_SINGLE && !stop |=> st_reg == S_IDLE)
      else $error("single scan did not stop");
   AST_CONT: assert property (store && last && mode == MODE_CONT && !stop
      |=> st_reg == S_CONV && ch_reg == $past(sch) && sample_en)
      else $error("continuous scan did not wrap");
   AST_PAUSE: assert property (store && mode == MODE_PAUSE && !stop |=> st_reg == S_PAUSE)
      else $error("pause mode did not halt");
   AST_XFER: assert property (st_reg == S_CONV && eng_done && pend_reg && xfer_en && !stop
      |=> st_reg == S_HOLD && $stable(data_reg))
      else $error("pending result overwritten");
   AST_ONE: assert property (store && sch == ech && last && !stop
      |=> ch_reg == $past(ch_reg))
      else $error("single-channel scan moved channel");

   COV_WRAP: cover property (store && last && mode == MODE_CONT);
   COV_HOLD: cover property (st_reg == S_HOLD ##1 st_reg == S_CONV);
   COV_PAUSE: cover property (st_reg == S_PAUSE ##1 st_reg == S_CONV);
endmodule // sar_adc_scan_control
`default_nettype wire

// ==== logic/adc_scan_consts.svh ====
// Constants of the converter scan control: offsets, fields, resets, timing.
// Assumes a 25 MHz core clock and 16-bit register data.
`ifndef ADC_SCAN_CONSTS_SVH
`define ADC_SCAN_CONSTS_SVH

`define ADC_CLK_NS        40
`define ADC_SAMPLE_NS     2000
`define ADC_CONV_NS       6120
`define ADC_SAMPLE_CYC    ((`ADC_SAMPLE_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_CONV_CYC      ((`ADC_CONV_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_STEP_CYC      (((`ADC_CONV_CYC - `ADC_SAMPLE_CYC) + 7) / 8)

`define ADC_OFF_CTRL      4'h0
`define ADC_OFF_STATUS    4'h1
`define ADC_OFF_DATA      4'h2
`define ADC_OFF_IRQ_STAT  4'h3
`define ADC_OFF_IRQ_MASK  4'h4

`define CTRL_START_BIT    0
`define CTRL_STOP_BIT     1
`define CTRL_MODE_LSB     2
`define CTRL_TRIG_LSB     4
`define CTRL_RES10_BIT    6
`define CTRL_XFER_BIT     7
`define CTRL_SCH_LSB      8
`define CTRL_ECH_LSB      11
`define CTRL_WR_MASK      16'h3ffc

`define IRQ_DONE_BIT      0
`define IRQ_OVR_BIT       1
`define IRQ_END_BIT       2

`define CTRL_RST          16'h0000
`define IRQ_MASK_RST      3'h0

`endif

// ==== logic/adc_scan_pkg.sv ====
// Types of the converter scan control.
// Assumes nothing beyond the consts header.
package adc_scan_pkg;
   typedef enum logic [1:0] {MODE_SINGLE, MODE_CONT, MODE_PAUSE} scan_mode_t;
   typedef enum logic [1:0] {TRIG_SOFT, TRIG_TIMER, TRIG_EXT} trig_src_t;
   typedef enum logic [1:0] {S_IDLE, S_CONV, S_HOLD, S_PAUSE} scan_state_t;
   typedef enum logic [1:0] {E_IDLE, E_SAMPLE, E_STEP} eng_state_t;
endpackage

// ==== logic/pin_fall_detect.sv ====
// Three-stage synchroniser with falling edge pulse for a pin input.
// Assumes the pin idles high.
`timescale 1ns/1ps
`default_nettype none
module pin_fall_detect
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Pin and edge
   input  wire logic pin,
   output logic      fall
);
   logic s1_reg, s2_reg, s3_reg, lvl_reg;
   logic lvl_next;

   always_comb
   begin
      lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
      fall     = lvl_reg & ~lvl_next;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg  <= 1'b1;
         s2_reg  <= 1'b1;
         s3_reg  <= 1'b1;
         lvl_reg <= 1'b1;
      end
      else
      begin
         s1_reg  <= pin;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         lvl_reg <= lvl_next;
      end
   end
endmodule // pin_fall_detect
`default_nettype wire

// ==== logic/sar_engine.sv ====
// Successive approximation sequencer: sample phase, then one step per bit.
// Assumes an on-chip comparator high when input is at or above dac_code.
`timescale 1ns/1ps
`default_nettype none
`include "adc_scan_consts.svh"
module sar_engine
#(
   parameter int SAMPLE_CYC = `ADC_SAMPLE_CYC,
   parameter int STEP_CYC   = `ADC_STEP_CYC,
   parameter int CONV_CYC   = `ADC_CONV_CYC
)
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic       res10,
   // Analog side
   input  wire logic       comp_in,
   output logic            sample_en,
   output logic [9:0]      dac_code,
   // Result
   output logic            busy,
   output logic            done,
   output logic [9:0]      result
);
   import adc_scan_pkg::*;

   if (SAMPLE_CYC < 1 || SAMPLE_CYC > 255 || STEP_CYC < 1 || STEP_CYC > 255)
      $error("sar_engine: cycle counts out of range");
   if (SAMPLE_CYC + 8 * STEP_CYC < CONV_CYC)
      $error("sar_engine: conversion shorter than minimum");

   eng_state_t st_reg, st_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [3:0] bit_reg, bit_next;
   logic [9:0] code_reg, code_next;
   logic [9:0] res_reg, res_next;
   logic       done_reg, done_next;
   logic [3:0] last_bit;

   always_comb
   begin
      st_next   = st_reg;
      cnt_next  = cnt_reg;
      bit_next  = bit_reg;
      code_next = code_reg;
      res_next  = res_reg;
      done_next = 1'b0;
      last_bit  = res10 ? 4'h0 : 4'h2;
      case (st_reg)
         E_IDLE:
         begin
            if (start)
            begin
               st_next   = E_SAMPLE;
               cnt_next  = 8'(SAMPLE_CYC - 1);
               code_next = 10'h000;
            end
         end
         E_SAMPLE:
         begin
            if (cnt_reg == 8'h00)
            begin
               st_next   = E_STEP;
               cnt_next  = 8'(STEP_CYC - 1);
               bit_next  = 4'h9;
               code_next = 10'h200;
            end
            else
               cnt_next = cnt_reg - 8'h01;
         end
         E_STEP:
         begin
            if (cnt_reg != 8'h00)
               cnt_next = cnt_reg - 8'h01;
            else
            begin
               if (!comp_in)
                  code_next[bit_reg] = 1'b0;
               if (bit_reg == last_bit)
               begin
                  st_next   = E_IDLE;
                  done_next = 1'b1;
                  res_next  = res10 ? code_next : {2'b00, code_next[9:2]};
               end
               else
               begin
                  bit_next  = bit_reg - 4'h1;
                  code_next[bit_reg - 4'h1] = 1'b1;
                  cnt_next  = 8'(STEP_CYC - 1);
               end
            end
         end
         default: st_next = E_IDLE;
      endcase
      if (abort)
      begin
         st_next   = E_IDLE;
         done_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg   <= E_IDLE;
         cnt_reg  <= 8'h00;
         bit_reg  <= 4'h0;
         code_reg <= 10'h000;
         res_reg  <= 10'h000;
         done_reg <= 1'b0;
      end
      else
      begin
         st_reg   <= st_next;
         cnt_reg  <= cnt_next;
         bit_reg  <= bit_next;
         code_reg <= code_next;
         res_reg  <= res_next;
         done_reg <= done_next;
      end
   end

   assign sample_en = (st_reg == E_SAMPLE);
   assign dac_code  = code_reg;
   assign busy      = (st_reg != E_IDLE);
   assign done      = done_reg;
   assign result    = res_reg;

   // Helper counters for phase lengths
   logic [8:0] samp_len, conv_len;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         samp_len <= 9'h000;
         conv_len <= 9'h000;
      end
      else
      begin
         samp_len <= sample_en ? samp_len + 9'h001 : 9'h000;
         conv_len <= busy ? conv_len + 9'h001 : 9'h000;
      end
   end

   AST_SAMPLE_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(sample_en) && !abort && !$past(abort) |-> samp_len >= 9'(SAMPLE_CYC))
      else $error("sample phase too short");
   AST_CONV_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
      done |-> conv_len >= 9'(CONV_CYC))
      else $error("conversion too short");
endmodule // sar_engine
`default_nettype wire

// ==== tb/analog_side_model.sv ====
// Analog side of the converter: eight channel levels, sample and hold, comparator.
// Assumes the converter drives chan_sel, sample_en and dac_code from core_clk.
`timescale 1ns/1ps
`default_nettype none
module analog_side_model
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Levels set by the bench, ten bits a channel
   input  wire logic [79:0] chan_level,
   // Converter side
   input  wire logic [2:0]  chan_sel,
   input  wire logic        sample_en,
   input  wire logic [9:0]  dac_code,
   output logic             comp_in,
   // Length of the last sample phase
   output logic      [15:0] samp_len
);
   logic [9:0]  held;
   logic [15:0] run_cnt;

   // Track while sampling, hold once the switch opens
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         held     <= 10'h000;
         run_cnt  <= 16'h0000;
         samp_len <= 16'h0000;
      end
      else if (sample_en)
      begin
         held    <= chan_level[chan_sel*10 +: 10];
         run_cnt <= run_cnt + 16'h0001;
      end
      else if (run_cnt != 16'h0000)
      begin
         samp_len <= run_cnt;
         run_cnt  <= 16'h0000;
      end
   end

   assign comp_in = (held >= dac_code);
endmodule // analog_side_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the converter scan control with random levels and ranges.
// Assumes the design and its header and package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "adc_scan_consts.svh"
module tb_top;
   import adc_scan_pkg::*;
   logic        core_clk, rst_n, reg_wr, reg_rd, timer_tick, ext_trig_pin;
   logic        comp_in, sample_en, auto_transfer_req, irq;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, samp_len, v;
   logic [9:0]  dac_code;
   logic [2:0]  chan_sel, sc, ec;
   logic [79:0] chan_level;
   int          failures, comparisons, seed, n;

   sar_adc_scan_control i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_tick(timer_tick),
      .ext_trig_pin(ext_trig_pin), .comp_in(comp_in), .sample_en(sample_en), .dac_code(dac_code),
      .chan_sel(chan_sel), .auto_transfer_req(auto_transfer_req), .irq(irq));
   analog_side_model i_ana (.core_clk(core_clk), .rst_n(rst_n), .chan_level(chan_level), .chan_sel(chan_sel),
      .sample_en(sample_en), .dac_code(dac_code), .comp_in(comp_in), .samp_len(samp_len));

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic close_out();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [15:0] ctrl_word(logic [1:0] md, logic [1:0] tr, logic r10, logic xf,
                                             logic [2:0] s, logic [2:0] e, logic st);
      ctrl_word = 16'h0000;
      ctrl_word[`CTRL_START_BIT] = st;
      ctrl_word[`CTRL_MODE_LSB +: 2] = md;
      ctrl_word[`CTRL_TRIG_LSB +: 2] = tr;
      ctrl_word[`CTRL_RES10_BIT] = r10;
      ctrl_word[`CTRL_XFER_BIT] = xf;
      ctrl_word[`CTRL_SCH_LSB +: 3] = s;
      ctrl_word[`CTRL_ECH_LSB +: 3] = e;
   endfunction

   // Result word: channel above, 8-bit results right-justified
   function automatic logic [15:0] exp_data(logic [2:0] ch, logic r10);
      logic [9:0] lv;
      lv = chan_level[ch*10 +: 10];
      exp_data = {3'h0, ch, r10 ? lv : {2'b00, lv[9:2]}};
   endfunction

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic wait_evt(input bit use_irq, output int cnt);
      cnt = 0;
      while ((use_irq ? irq : auto_transfer_req) !== 1'b1)
      begin
         if (cnt == 2000)
         begin
            $display("[ERR] event_wait expected 1 seen 0");
            failures++;
            close_out();
         end
         @(posedge core_clk);
         #1;
         cnt++;
      end
   endtask

   task automatic fire(input trig_src_t tr, input logic [15:0] cfg);
      if (tr == TRIG_SOFT)
         wr(`ADC_OFF_CTRL, cfg | 16'h0001);
      else if (tr == TRIG_TIMER)
      begin
         @(posedge core_clk);
         timer_tick <= 1'b1;
         @(posedge core_clk);
         timer_tick <= 1'b0;
      end
      else
      begin
         @(posedge core_clk);
         ext_trig_pin <= 1'b0;
         repeat (6) @(posedge core_clk);
         ext_trig_pin <= 1'b1;
      end
   endtask

   task automatic run_scan(input scan_mode_t md, input trig_src_t tr, input logic r10,
                           input logic [2:0] s, input logic [2:0] e, input int cnt);
      logic [15:0] cfg, d;
      int          span, w;
      cfg  = ctrl_word(md, tr, r10, 1'b1, s, e, 1'b0);
      span = int'(3'(e - s)) + 1;
      wr(`ADC_OFF_CTRL, cfg);
      if (tr != TRIG_SOFT)
      begin
         wr(`ADC_OFF_CTRL, cfg | 16'h0001);
         repeat (100) @(posedge core_clk);
         rd(`ADC_OFF_STATUS, d);
         check("soft_start_ignored", {15'h0, d[0]}, 16'h0000);
      end
      for (int k = 0; k < cnt; k++)
      begin
         if (k == 0 || md == MODE_PAUSE)
            fire(tr, cfg);
         wait_evt(1'b0, w);
         if (k == 0 || md == MODE_PAUSE)
            check("conv_cycles", {15'h0, w >= `ADC_CONV_CYC}, 16'h0001);
         check("sample_cycles", {15'h0, samp_len >= `ADC_SAMPLE_CYC}, 16'h0001);
         rd(`ADC_OFF_DATA, d);
         check("data", d, exp_data(3'(s + 3'(k % span)), r10));
      end
      if (md == MODE_CONT)
         wr(`ADC_OFF_CTRL, cfg | 16'h0002);
      repeat (300) @(posedge core_clk);
      #1 check("no_more_results", {15'h0, auto_transfer_req}, 16'h0000);
      check("irq_masked", {15'h0, irq}, 16'h0000);
      rd(`ADC_OFF_STATUS, d);
      check("paused", {15'h0, d[1]}, {15'h0, md == MODE_PAUSE});
      wr(`ADC_OFF_CTRL, cfg | 16'h0002);
      rd(`ADC_OFF_STATUS, d);
      check("busy_after", {15'h0, d[0]}, 16'h0000);
      rd(`ADC_OFF_IRQ_STAT, d);
      if (md == MODE_SINGLE)
         check("irq_stat", d, 16'h0005);
      $display("test scan mode %0d trig %0d done", md, tr);
   endtask

   initial
   begin
      seed = 32'h8eed6ce3;
      failures = 0;
      comparisons = 0;
      rst_n = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      timer_tick = 1'b0;
      ext_trig_pin = 1'b1;
      chan_level = 80'h0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`ADC_OFF_CTRL, v);
      check("ctrl_reset", v, `CTRL_RST);
      rd(`ADC_OFF_IRQ_MASK, v);
      check("mask_reset", v, {13'h0, `IRQ_MASK_RST});
      rd(`ADC_OFF_STATUS, v);
      check("status_reset", v, 16'h0000);
      wr(4'hf, 16'hffff);
      rd(4'hf, v);
      check("unmapped", v, 16'h0000);
      $display("test reset_map done");
      for (int t = 0; t < 4; t++)
      begin
         for (int c = 0; c < 8; c++)
            chan_level[c*10 +: 10] <= 10'($random(seed));
         sc = 3'($random(seed));
         ec = (t == 1) ? sc : 3'($random(seed));
         if (t == 3)
         begin
            sc = 3'h6;
            ec = 3'h1;
         end
         run_scan(MODE_SINGLE, trig_src_t'(t % 3), 1'($random(seed)), sc, ec, int'(3'(ec - sc)) + 1);
      end
      run_scan(MODE_CONT, TRIG_SOFT, 1'b1, 3'h7, 3'h0, 5);
      run_scan(MODE_PAUSE, TRIG_TIMER, 1'b0, 3'h1, 3'h2, 3);
      // Trigger source and channels come from the stored config, so set it first
      wr(`ADC_OFF_IRQ_MASK, 16'h0001);
      wr(`ADC_OFF_CTRL, ctrl_word(MODE_SINGLE, TRIG_SOFT, 1'b1, 1'b0, 3'h4, 3'h4, 1'b0));
      wr(`ADC_OFF_CTRL, ctrl_word(MODE_SINGLE, TRIG_SOFT, 1'b1, 1'b0, 3'h4, 3'h4, 1'b1));
      wait_evt(1'b1, n);
      check("req_off", {15'h0, auto_transfer_req}, 16'h0000);
      rd(`ADC_OFF_DATA, v);
      check("irq_data", v, exp_data(3'h4, 1'b1));
      rd(`ADC_OFF_IRQ_STAT, v);
      check("irq_stat_done", v, 16'h0005);
      repeat (2) @(posedge core_clk);
      #1 check("irq_cleared", {15'h0, irq}, 16'h0000);
      $display("test irq done");
      wr(`ADC_OFF_IRQ_MASK, 16'h0004);
      wr(`ADC_OFF_CTRL, ctrl_word(MODE_SINGLE, TRIG_SOFT, 1'b0, 1'b0, 3'h0, 3'h1, 1'b0));
      wr(`ADC_OFF_CTRL, ctrl_word(MODE_SINGLE, TRIG_SOFT, 1'b0, 1'b0, 3'h0, 3'h1, 1'b1));
      wait_evt(1'b1, n);
      rd(`ADC_OFF_IRQ_STAT, v);
      check("irq_stat_overrun", v, 16'h0007);
      rd(`ADC_OFF_DATA, v);
      check("overrun_data", v, exp_data(3'h1, 1'b0));
      $display("test overrun done");
      // Slow reader: second result must wait unread results out, none lost
      wr(`ADC_OFF_CTRL, ctrl_word(MODE_SINGLE, TRIG_SOFT, 1'b1, 1'b1, 3'h2, 3'h4, 1'b0));
      wr(`ADC_OFF_CTRL, ctrl_word(MODE_SINGLE, TRIG_SOFT, 1'b1, 1'b1, 3'h2, 3'h4, 1'b1));
      repeat (500) @(posedge core_clk);
      for (int k = 0; k < 3; k++)
      begin
         wait_evt(1'b0, n);
         rd(`ADC_OFF_DATA, v);
         check("held_data", v, exp_data(3'(3'h2 + 3'(k)), 1'b1));
      end
      rd(`ADC_OFF_IRQ_STAT, v);
      check("held_no_overrun", v, 16'h0005);
      $display("test hold done");
      close_out();
   end
endmodule // tb_top
`default_nettype wire
